// ### lscr_consts.svh
/*
 * Offsets, field positions and reset values of the link and slot registers.
 * Assumes byte addresses on the configuration port and 32-bit words.
 */
`ifndef LSCR_CONSTS_SVH
`define LSCR_CONSTS_SVH

`define LSCR_AW             8
`define LSCR_OFF_LINK       8'hc0
`define LSCR_OFF_SLOTCAP    8'hc4
`define LSCR_OFF_SLOT       8'hc8
`define LSCR_OFF_IRQ_STAT   8'he8
`define LSCR_OFF_IRQ_MASK   8'hec
`define LSCR_OFF_EVENT      8'hf0

`define LSCR_ASPM_RST       2'h0
`define LSCR_SPEED_RST      4'h1
`define LSCR_WIDTH_RST      6'h01
`define LSCR_SLOTCLK_RST    1'h1
`define LSCR_SLOTCTL_W      11
`define LSCR_SLOTCTL_RST    11'h000
`define LSCR_NEVT           5
`define LSCR_NIRQ           6
`define LSCR_IRQ_TRAIN      5

`endif

// ### lscr_pkg.sv
/*
 * Types shared by the link and slot register block.
 * Assumes the constants header is compiled alongside.
 */
package lscr_pkg;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } lscr_bus_t;

    typedef struct packed {
        logic [5:0] width;
        logic       train_err;
        logic       training;
    } lscr_link_in_t;

    typedef struct packed {
        logic [1:0]  aspm;
        logic        link_dis;
        logic        retrain;
        logic        common_clk;
        logic        ext_sync;
        logic [10:0] slot_ctl;
    } lscr_ctl_t;

    typedef struct packed {
        lscr_ctl_t   ctl;
        logic [3:0]  speed;
        logic [5:0]  width;
        logic        train_err;
        logic        training;
        logic        training_d;
        logic        mrl_state;
        logic        pres_state;
        logic [4:0]  slot_evt;
        logic [5:0]  irq_stat;
        logic [5:0]  irq_mask;
        logic        hp_strap;
        logic        strap_done;
        logic [31:0] rdata;
        logic        irq;
    } lscr_state_t;

endpackage

// ### lscr_regs.sv
/*
 * Link control/status and slot capability/control/status registers.
 * Assumes a one-cycle configuration port, synchronous inputs, one clock.
 */
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "lscr_consts.svh"
//
// Contract
// - Two-bit power-state control: 00 off, 01 L0s, 10 L1, 11 both; reset 00.
// - Read completion boundary bit reads zero and ignores writes.
// - Link disable and retrain read-only in forward mode; writable in reverse; reset 0.
// - Negotiated speed field is read-only, value 1 for 2.5Gb/s, reset 1.
// - Hot-plug presence capability bits read 1 only with hot plug in reverse mode.
// - Presence capability bits load from the hot-plug strap at reset release.
// - Slot control enables, indicator controls, power control writable, reset zero.
module lscr_regs (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rstn,
    // Configuration port
    input  wire lscr_pkg::lscr_bus_t   i_bus,
    output logic [31:0]                o_rdata,
    // Mode and strap
    input  wire logic                  i_reverse,
    input  wire logic                  i_hp_strap,
    // Link and slot inputs
    input  wire lscr_pkg::lscr_link_in_t i_link,
    input  wire logic [4:0]            i_slot_evt,
    input  wire logic                  i_mrl_state,
    input  wire logic                  i_pres_state,
    // Control out
    output lscr_pkg::lscr_ctl_t        o_ctl,
    output logic                       o_irq
);
    import lscr_pkg::*;

    lscr_state_t s_r;
    lscr_state_t s_nxt;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    function automatic logic [31:0] rd_mux(input lscr_state_t s, input logic [7:0] a,
                                           input logic rev);
        logic        hp;
        logic [31:0] v;
        hp = s.hp_strap & rev;
        v  = 32'h0000_0000;
        if (hit(a, `LSCR_OFF_LINK)) begin
            v[1:0]   = s.ctl.aspm;
            v[3]     = 1'b0;
            v[4]     = s.ctl.link_dis;
            v[5]     = s.ctl.retrain;
            v[6]     = s.ctl.common_clk;
            v[7]     = s.ctl.ext_sync;
            v[19:16] = s.speed;
            v[25:20] = s.width;
            v[26]    = s.train_err;
            v[27]    = s.training;
            v[28]    = `LSCR_SLOTCLK_RST;
        end else if (hit(a, `LSCR_OFF_SLOTCAP)) begin
            v[0] = hp;
            v[2] = hp;
            v[3] = hp;
            v[4] = hp;
            v[6] = hp;
        end else if (hit(a, `LSCR_OFF_SLOT)) begin
            v[10:0]  = s.ctl.slot_ctl;
            v[20:16] = s.slot_evt;
            v[21]    = s.mrl_state;
            v[22]    = s.pres_state;
        end else if (hit(a, `LSCR_OFF_IRQ_STAT)) begin
            v[5:0] = s.irq_stat;
        end else if (hit(a, `LSCR_OFF_IRQ_MASK)) begin
            v[5:0] = s.irq_mask;
        end else if (hit(a, `LSCR_OFF_EVENT)) begin
            v[4:0] = s.slot_evt;
        end
        return v;
    endfunction

    always_comb begin
        logic [5:0] ev;
        logic       rd_stat;
        s_nxt = s_r;
        ev = {s_r.training & ~s_r.training_d, i_slot_evt};
        rd_stat = i_bus.rd & hit(i_bus.addr, `LSCR_OFF_IRQ_STAT);
        // Strap sampled once, on the first edge after reset release
        if (!s_r.strap_done) begin
            s_nxt.hp_strap   = i_hp_strap;
            s_nxt.strap_done = 1'b1;
        end
        s_nxt.width      = i_link.width;
        s_nxt.train_err  = i_link.train_err;
        s_nxt.training   = i_link.training;
        s_nxt.training_d = s_r.training;
        s_nxt.mrl_state  = i_mrl_state;
        s_nxt.pres_state = i_pres_state;
        s_nxt.speed      = `LSCR_SPEED_RST;
        // Slot events latch until software writes one to clear
        if (i_bus.wr && hit(i_bus.addr, `LSCR_OFF_EVENT))
            s_nxt.slot_evt = s_r.slot_evt & ~i_bus.wdata[4:0];
        s_nxt.slot_evt = s_nxt.slot_evt | i_slot_evt;
        // Read clears status; a coincident event still lands
        s_nxt.irq_stat = (rd_stat ? 6'h00 : s_r.irq_stat) | ev;
        if (i_bus.wr) begin
            if (hit(i_bus.addr, `LSCR_OFF_LINK)) begin
                s_nxt.ctl.aspm       = i_bus.wdata[1:0];
                s_nxt.ctl.common_clk = i_bus.wdata[6];
                s_nxt.ctl.ext_sync   = i_bus.wdata[7];
                if (i_reverse) begin
                    s_nxt.ctl.link_dis = i_bus.wdata[4];
                    s_nxt.ctl.retrain  = i_bus.wdata[5];
                end
            end else if (hit(i_bus.addr, `LSCR_OFF_SLOT)) begin
                s_nxt.ctl.slot_ctl = i_bus.wdata[10:0];
            end else if (hit(i_bus.addr, `LSCR_OFF_IRQ_MASK)) begin
                s_nxt.irq_mask = i_bus.wdata[5:0];
            end
        end
        // Retrain is a one-shot request in the reverse direction
        if (s_r.ctl.retrain && !(i_bus.wr && hit(i_bus.addr, `LSCR_OFF_LINK)))
            s_nxt.ctl.retrain = 1'b0;
        s_nxt.rdata = i_bus.rd ? rd_mux(s_r, i_bus.addr, i_reverse) : 32'h0000_0000;
        s_nxt.irq   = |(s_nxt.irq_stat & s_nxt.irq_mask);
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_r            <= '0;
            s_r.ctl.aspm   <= `LSCR_ASPM_RST;
            s_r.ctl.slot_ctl <= `LSCR_SLOTCTL_RST;
            s_r.speed      <= `LSCR_SPEED_RST;
            s_r.width      <= `LSCR_WIDTH_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rdata = s_r.rdata;
    assign o_ctl   = s_r.ctl;
    assign o_irq   = s_r.irq;

endmodule // lscr_regs

// ### lscr_regs_assertions.sv
/* Assertions for the link and slot register block.
   Bound to lscr_regs; sees its ports only, strap held steady outside reset. */
`timescale 1ns/1ps
module lscr_regs_assertions (
    // Clock and reset
    input wire logic                i_clk,
    input wire logic                i_rstn,
    // Watched ports
    input wire lscr_pkg::lscr_bus_t i_bus,
    input wire logic [31:0]         o_rdata,
    input wire logic                i_reverse,
    input wire logic                i_hp_strap,
    input wire lscr_pkg::lscr_ctl_t o_ctl
);
    import lscr_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire wr_c0 = i_bus.wr && i_bus.addr == 8'hc0;
    wire rd_c0 = i_bus.rd && i_bus.addr == 8'hc0;
    wire rd_c4 = i_bus.rd && i_bus.addr == 8'hc4;
    wire wr_c8 = i_bus.wr && i_bus.addr == 8'hc8;
    AST_ASPM: assert property (wr_c0 |=> o_ctl.aspm == $past(i_bus.wdata[1:0]))
        else $error("power-state field not written");
    AST_RSVD: assert property (
        rd_c0 |=> o_rdata[3:2] == 2'h0 && o_rdata[15:8] == 8'h00 && o_rdata[31:29] == 3'h0)
        else $error("reserved or boundary bit nonzero");
    AST_FWD: assert property (wr_c0 && !i_reverse |=> $stable(o_ctl.link_dis))
        else $error("link disable written in forward mode");
    AST_REV: assert property (wr_c0 && i_reverse |=> o_ctl.link_dis == $past(i_bus.wdata[4]))
        else $error("link disable not written in reverse mode");
    AST_SPEED: assert property (rd_c0 |=> o_rdata[19:16] == 4'h1)
        else $error("link speed wrong");
    AST_CAP: assert property (
        rd_c4 |=> o_rdata[6:0] == ({7{$past(i_reverse && i_hp_strap)}} & 7'h5d))
        else $error("slot capability presence bits wrong");
    AST_SLOT: assert property (wr_c8 |=> o_ctl.slot_ctl == $past(i_bus.wdata[10:0]))
        else $error("slot control not written");
    AST_IDLE: assert property (!i_bus.rd |=> o_rdata == 32'h0)
        else $error("read data outside read slot");
endmodule // lscr_regs_assertions

bind lscr_regs lscr_regs_assertions lscr_regs_assertions_i (.i_clk, .i_rstn, .i_bus,
    .o_rdata, .i_reverse, .i_hp_strap, .o_ctl);

// ### test_lscr_regs.sv
/* Self-checking bench for the link and slot register block.
   Drives the configuration port directly; link inputs held at an x1 idle link. */
`timescale 1ns/1ps
module test_lscr_regs;
    import lscr_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} lscr_row_t;
    logic          i_clk = 0, i_rstn = 0, i_reverse = 1, i_hp_strap = 1, o_irq;
    logic          i_mrl_state = 0, i_pres_state = 0;
    logic [4:0]    i_slot_evt = 5'h00;
    logic [31:0]   o_rdata, rd_v;
    lscr_bus_t     i_bus = '0;
    lscr_link_in_t i_link = '{6'h01, 1'b0, 1'b0};
    lscr_ctl_t     o_ctl;
    int            error_cnt = 0, check_count = 0, cyc = 0;
    // Last link row leaves link disable set for the forward-mode test
    lscr_row_t     rows [8] = '{'{8'hc0, 32'h1, 32'h10110001}, '{8'hc0, 32'h2, 32'h10110002},
        '{8'hc0, 32'hffffffdf, 32'h101100d3}, '{8'hc8, 32'hffffffff, 32'h7ff},
        '{8'hc8, 32'h555, 32'h555}, '{8'hc4, 32'hffffffff, 32'h5d},
        '{8'h10, 32'hffffffff, 32'h0}, '{8'hec, 32'hffffffff, 32'h3f}};
    lscr_regs lscr_regs_i (.i_clk, .i_rstn, .i_bus, .o_rdata, .i_reverse, .i_hp_strap,
        .i_link, .i_slot_evt, .i_mrl_state, .i_pres_state, .o_ctl, .o_irq);
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            results();
        end
    end
    task results();
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk) i_bus <= '{1'b1, 1'b0, a, d};
        @(posedge i_clk) i_bus <= '0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge i_clk) i_bus <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge i_clk) i_bus <= '0;
        #1 rd_v = o_rdata;
    endtask
    task rst(input logic s);
        i_rstn <= 1'b0;
        i_hp_strap <= s;
        repeat (10) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_clk);
    endtask
    task irq_after(input int n, input logic e);
        repeat (n) @(posedge i_clk);
        // Look after the edge has settled, not in its own time step
        #1 chk("irq", {31'h0, o_irq}, {31'h0, e});
    endtask
    initial begin
        rst(1'b1);
        rd(8'hc0);
        chk("link reset", rd_v, 32'h10110000);
        rd(8'hc8);
        chk("slot reset", rd_v, 32'h0);
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].d);
            rd(rows[k].a);
            chk("row", rd_v, rows[k].e);
        end
        // Forward mode: link disable must hold, capability bits drop
        i_reverse <= 1'b0;
        wr(8'hc0, 32'h0);
        rd(8'hc0);
        chk("forward link", rd_v, 32'h10110010);
        chk("forward ctl", {15'h0, o_ctl}, 32'h4555);
        rd(8'hc4);
        chk("forward cap", rd_v, 32'h0);
        i_reverse <= 1'b1;
        // Retrain written in reverse mode is a one-cycle request
        wr(8'hc0, 32'h20);
        #1 chk("retrain", {31'h0, o_ctl.retrain}, 32'h1);
        @(posedge i_clk) #1 chk("retrain end", {31'h0, o_ctl.retrain}, 32'h0);
        // Masked event, then unmask, then read-clear
        wr(8'hec, 32'h0);
        @(posedge i_clk) i_slot_evt <= 5'h01;
        @(posedge i_clk) i_slot_evt <= 5'h00;
        irq_after(2, 1'b0);
        wr(8'hec, 32'h1);
        irq_after(2, 1'b1);
        rd(8'he8);
        chk("irq status", rd_v, 32'h1);
        irq_after(2, 1'b0);
        rst(1'b0);
        rd(8'hc4);
        chk("strap off cap", rd_v, 32'h0);
        results();
    end
endmodule // test_lscr_regs
